// File: ingress_rules.v
// ingress rule registers and per-frame classification decision of a three-port switch
`timescale 1ns/1ps
`include "ingress_rules_defines.vh"
module ingress_rules (
	// clock and reset
	input  wire        clk,
	input  wire        rst_n,
	// register port
	input  wire        reg_wr,
	input  wire        reg_rd,
	input  wire [15:0] reg_addr,
	input  wire [31:0] reg_wdata,
	output reg  [31:0] reg_rdata,
	// diffserv table write port
	input  wire        ds_wr,
	input  wire [5:0]  ds_idx,
	input  wire [2:0]  ds_wdata,
	// other switch configuration
	input  wire [5:0]  port_spanning_state,
	input  wire [2:0]  admit_non_member_mask,
	input  wire [35:0] port_default_vlan_id,
	// frame header from the parser, sampled on frame_start
	input  wire        frame_start,
	input  wire [1:0]  rx_port,
	input  wire        tag_present,
	input  wire [11:0] tag_vid,
	input  wire [2:0]  tag_prio,
	input  wire        ip_valid,
	input  wire        ip_is_v4,
	input  wire [5:0]  ip_tos,
	input  wire        is_igmp,
	input  wire        da_mcast,
	input  wire        da_bcast,
	// address_table lookup and vlan table results
	input  wire        da_found,
	input  wire [2:0]  da_ports,
	input  wire        da_prio_en,
	input  wire [2:0]  da_prio,
	input  wire [2:0]  vlan_members,
	input  wire [2:0]  port_default_prio,
	// counter read hook
	input  wire        cnt_read,
	input  wire [31:0] cnt_value,
	output reg  [31:0] cnt_reload,
	// decision, valid one cycle after frame_start
	output reg         dec_valid,
	output reg  [11:0] dec_vid,
	output reg  [2:0]  dec_prio,
	output reg  [2:0]  dec_dest,
	output reg         dec_drop,
	output reg         dec_learn
);
	// configuration registers
	reg  [15:0] global_ingress_rules_r;
	reg  [5:0]  per_port_ingress_rules_r;
	// priority table, one entry per six-bit class value
	reg  [2:0]  diffserv_mem [0:63];
	// decoded global settings
	wire        vid_ignore;
	wire        use_tag;
	wire        mon_echo;
	wire [2:0]  igmp_map;
	wire        use_ip;
	wire        igmp_en;
	wire        cnt_test;
	wire        da_prio_on;
	wire        filt_mcast;
	wire        drop_unknown;
	wire        use_prec;
	wire        vl_higher;
	wire        vlan_en;
	// per port views
	wire [2:0]  learn_en;
	wire [2:0]  member_chk_en;
	wire [2:0]  learn_ok;
	wire [2:0]  rx_onehot;
	wire [11:0] dflt_vid;
	// frame classification
	wire        tag_usable;
	wire        ip_usable;
	wire        igmp_hit;
	wire        unknown_da;
	wire [2:0]  ip_prio;
	reg  [2:0]  prio_nxt;
	reg         mbr_on;
	reg         mbr_drop;
	reg         filt_drop;
	reg  [2:0]  dest_fwd;
	reg  [2:0]  dest_nxt;
	reg         drop_nxt;
	reg  [11:0] vid_nxt;
	reg         learn_nxt;
	reg  [31:0] rdata_nxt;
	reg  [31:0] reload_nxt;
	genvar      g;

	// global field decode
	assign vid_ignore   = global_ingress_rules_r[`GB_VID_IGNORE];
	assign use_tag      = global_ingress_rules_r[`GB_USE_TAG];
	assign mon_echo     = global_ingress_rules_r[`GB_MON_ECHO];
	assign igmp_map     = global_ingress_rules_r[`GB_IGMP_MAP_HI:`GB_IGMP_MAP_LO];
	assign use_ip       = global_ingress_rules_r[`GB_USE_IP];
	assign igmp_en      = global_ingress_rules_r[`GB_IGMP_EN];
	assign cnt_test     = global_ingress_rules_r[`GB_CNT_TEST];
	assign da_prio_on   = global_ingress_rules_r[`GB_DA_PRIO];
	assign filt_mcast   = global_ingress_rules_r[`GB_FILT_MCAST];
	assign drop_unknown = global_ingress_rules_r[`GB_DROP_UNKNOWN];
	assign use_prec     = global_ingress_rules_r[`GB_USE_PREC];
	assign vl_higher    = global_ingress_rules_r[`GB_VL_HIGHER];
	assign vlan_en      = global_ingress_rules_r[`GB_VLAN_EN];

	// one slice per port; bit n of each per-port field belongs to port n
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_port
			assign learn_en[g]      = per_port_ingress_rules_r[`PP_LEARN_LO + g];
			assign member_chk_en[g] = per_port_ingress_rules_r[g];
			// port code 3 selects no port here, though dflt_vid takes the port 0 vid for it
			assign rx_onehot[g]     = (rx_port == g);
			assign learn_ok[g]      = learn_en[g] &&
				((port_spanning_state[2*g+1:2*g] == `STP_FORWARD) ||
				 (port_spanning_state[2*g+1:2*g] == `STP_LEARN));
		end
	endgenerate

	assign dflt_vid = (rx_port == 2'h2) ? port_default_vlan_id[35:24] :
		(rx_port == 2'h1) ? port_default_vlan_id[23:12] :
		port_default_vlan_id[11:0];

	assign tag_usable = use_tag && tag_present;
	assign ip_usable  = use_ip && ip_valid;
	assign igmp_hit   = igmp_en && is_igmp && ip_is_v4;
	assign unknown_da = !da_found;
	assign ip_prio    = (ip_is_v4 && use_prec) ? ip_tos[5:3] : diffserv_mem[ip_tos];

	// queue priority: table entry first, then tag or ip by bit 1, then port default
	always @* begin
		prio_nxt = port_default_prio;
		if (da_prio_on && da_found && da_prio_en) begin
			prio_nxt = da_prio;
		end else if (tag_usable && (vl_higher || !ip_usable)) begin
			prio_nxt = tag_prio;
		end else if (ip_usable) begin
			prio_nxt = ip_prio;
		end else begin
			prio_nxt = port_default_prio;
		end
	end

	// membership check applies only with the global vlan enable set
	always @* begin
		mbr_on   = vlan_en && |(member_chk_en & rx_onehot);
		mbr_drop = 1'b0;
		if (mbr_on) begin
			if (!(|(vlan_members & rx_onehot)) && !(|(admit_non_member_mask & rx_onehot))) begin
				mbr_drop = 1'b1;
			end
		end
	end

	// unknown destination filters; broadcasts never count as unknown multicast
	always @* begin
		filt_drop = 1'b0;
		if (unknown_da && da_mcast && !da_bcast && filt_mcast) begin
			filt_drop = 1'b1;
		end
		if (unknown_da && !da_mcast && !da_bcast && drop_unknown) begin
			filt_drop = 1'b1;
		end
	end

	// destination set; igmp monitoring overrides the filters above
	always @* begin
		dest_fwd = da_found ? da_ports : 3'h7;
		if (mbr_on && da_found) begin
			dest_fwd = dest_fwd & vlan_members;
		end
		dest_nxt = dest_fwd & ~rx_onehot;
		drop_nxt = mbr_drop || filt_drop;
		if (igmp_hit) begin
			dest_nxt = igmp_map;
			if (!mon_echo) begin
				dest_nxt = dest_nxt & ~rx_onehot;
			end
			drop_nxt = 1'b0;
		end
		// an empty port set is a drop, so dest and drop never disagree
		if (dest_nxt == 3'h0) begin
			drop_nxt = 1'b1;
		end
	end

	// untagged or priority-tagged frames take the port default vid
	always @* begin
		if (vid_ignore || !tag_present || (tag_vid == 12'h000)) begin
			vid_nxt = dflt_vid;
		end else begin
			vid_nxt = tag_vid;
		end
		learn_nxt = |(learn_ok & rx_onehot);
	end

	// register writes; the frame logic samples them only at frame_start
	always @(posedge clk) begin
		if (!rst_n) begin
			global_ingress_rules_r   <= `GLOBAL_RESET;
			per_port_ingress_rules_r <= `PER_PORT_RESET;
		end else if (reg_wr) begin
			if (reg_addr == `GLOBAL_INGRESS_RULES_IDX) begin
				global_ingress_rules_r <= reg_wdata[15:0];
			end
			if (reg_addr == `PER_PORT_INGRESS_RULES_IDX) begin
				per_port_ingress_rules_r <= reg_wdata[5:0];
			end
		end
	end

	// read mux; bits above each register's width and unmapped indices read as zero, global bit 8 reads back as written
	always @* begin
		case (reg_addr)
			`GLOBAL_INGRESS_RULES_IDX: begin
				rdata_nxt = {16'h0000, global_ingress_rules_r};
			end
			`PER_PORT_INGRESS_RULES_IDX: begin
				rdata_nxt = {26'h0000000, per_port_ingress_rules_r};
			end
			default: begin
				rdata_nxt = 32'h0000_0000;
			end
		endcase
	end

	// read data stands until the next read
	always @(posedge clk) begin
		if (!rst_n) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			reg_rdata <= rdata_nxt;
		end
	end

	// table not reset, software must fill it before enabling class lookup
	always @(posedge clk) begin
		if (ds_wr) begin
			diffserv_mem[ds_idx] <= ds_wdata;
		end
	end

	// clear-on-read counters reload with the test pattern in test mode
	always @* begin
		if (cnt_test) begin
			reload_nxt = `CNT_TEST_VALUE;
		end else begin
			reload_nxt = 32'h0000_0000;
		end
	end

	always @(posedge clk) begin
		if (!rst_n) begin
			cnt_reload <= 32'h0000_0000;
		end else if (cnt_read) begin
			cnt_reload <= reload_nxt;
		end
	end

	// decision registered from the settings in force at frame start
	always @(posedge clk) begin
		if (!rst_n) begin
			dec_valid <= 1'b0;
			dec_vid   <= 12'h000;
			dec_prio  <= 3'h0;
			dec_dest  <= 3'h0;
			dec_drop  <= 1'b0;
			dec_learn <= 1'b0;
		end else begin
			dec_valid <= frame_start;
			if (frame_start) begin
				dec_vid   <= vid_nxt;
				dec_prio  <= prio_nxt;
				dec_dest  <= drop_nxt ? 3'h0 : dest_nxt;
				dec_drop  <= drop_nxt;
				dec_learn <= learn_nxt;
			end
		end
	end
endmodule

// File: ingress_rules_defines.vh
// register offsets, field positions, reset values and constants of the ingress rule block
`ifndef INGRESS_RULES_DEFINES_VH
`define INGRESS_RULES_DEFINES_VH
`define GLOBAL_INGRESS_RULES_IDX   16'h1840
`define PER_PORT_INGRESS_RULES_IDX 16'h1841
`define GLOBAL_RESET       16'h0006
`define PER_PORT_RESET     6'h38
`define GB_VID_IGNORE      15
`define GB_USE_TAG         14
`define GB_MON_ECHO        13
`define GB_IGMP_MAP_HI     12
`define GB_IGMP_MAP_LO     10
`define GB_USE_IP          9
`define GB_IGMP_EN         7
`define GB_CNT_TEST        6
`define GB_DA_PRIO         5
`define GB_FILT_MCAST      4
`define GB_DROP_UNKNOWN    3
`define GB_USE_PREC        2
`define GB_VL_HIGHER       1
`define GB_VLAN_EN         0
`define PP_LEARN_LO        3
`define CNT_TEST_VALUE     32'h7FFF_FFFC
`define STP_FORWARD        2'h0
`define STP_LEARN          2'h2
`endif

// File: ingress_rules_chk.sv
// assertions on the ingress rule block ports
`timescale 1ns/1ps
`include "ingress_rules_defines.vh"
module ingress_rules_chk (
	input wire        clk, rst_n, reg_wr, reg_rd, frame_start, is_igmp, da_mcast, da_bcast,
	input wire        da_found, da_prio_en, cnt_read, dec_valid, dec_drop, dec_learn,
	input wire [15:0] reg_addr,
	input wire [31:0] reg_wdata, reg_rdata, cnt_reload,
	input wire [5:0]  port_spanning_state,
	input wire [35:0] port_default_vlan_id,
	input wire [1:0]  rx_port,
	input wire [2:0]  da_prio, dec_prio, dec_dest,
	input wire [11:0] dec_vid
);
	// settings mirrored from the write strobes, so checks follow live configuration
	reg  [15:0] g_r;
	reg  [5:0]  p_r;
	wire [11:0] pv = port_default_vlan_id[rx_port * 12 +: 12];
	wire        lrn = p_r[3 + rx_port] & ~port_spanning_state[rx_port * 2];
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	always @(posedge clk) begin
		if (!rst_n) begin
			g_r <= `GLOBAL_RESET;
			p_r <= `PER_PORT_RESET;
		end else if (reg_wr && reg_addr == `GLOBAL_INGRESS_RULES_IDX)
			g_r <= reg_wdata[15:0];
		else if (reg_wr && reg_addr == `PER_PORT_INGRESS_RULES_IDX)
			p_r <= reg_wdata[5:0];
	end
	valid_pulse_a: assert property (dec_valid == $past(frame_start))
		else $error("decision strobe late or missing");
	drop_empty_a: assert property (dec_drop |-> dec_dest == 3'h0)
		else $error("dropped frame still has ports");
	echo_block_a: assert property (frame_start && !g_r[13] |=> !dec_dest[$past(rx_port)])
		else $error("frame sent back to source");
	learn_gate_a: assert property (frame_start |=> dec_learn == $past(lrn))
		else $error("learn decision wrong");
	unknown_uni_a: assert property (frame_start && g_r[3] &&
		!(da_found | da_mcast | da_bcast | is_igmp) |=> dec_drop)
		else $error("unknown unicast kept");
	unknown_mc_a: assert property (frame_start && g_r[4] && da_mcast &&
		!(da_found | da_bcast | is_igmp) |=> dec_drop)
		else $error("unknown multicast kept");
	vid_ignore_a: assert property (frame_start && g_r[15] && g_r[0] |=> dec_vid == $past(pv))
		else $error("tag vid not replaced");
	da_prio_a: assert property (frame_start && g_r[5] && da_found && da_prio_en |=>
		dec_prio == $past(da_prio))
		else $error("table priority not used");
	cnt_test_a: assert property (cnt_read |=>
		cnt_reload == ($past(g_r[6]) ? `CNT_TEST_VALUE : 32'h0))
		else $error("counter reload value wrong");
	read_back_a: assert property (reg_rd && reg_addr == `GLOBAL_INGRESS_RULES_IDX |=>
		reg_rdata == {16'h0, $past(g_r)})
		else $error("global read back wrong");
endmodule

// File: frame_src.sv
// received frame header source standing in for the switch ports
`timescale 1ns/1ps
module frame_src (
	input  wire        clk,
	input  wire        go,
	output reg         fs,
	output reg  [42:0] h
);
	integer seed = 11;
	// header scrambles every cycle so stale fields never look valid
	always @(posedge clk) begin
		fs <= #1 go;
		// ingress port limited to the three real ports
		h <= #1 {2'({$random(seed)} % 3), 41'({$random(seed), $random(seed)})};
	end
endmodule

// File: switch_ingress_rule_config_tb.sv
// self-checking bench for the ingress rule block
`timescale 1ns/1ps
`include "ingress_rules_defines.vh"
module switch_ingress_rule_config_tb;
	logic        clk, rst_n, reg_wr, reg_rd, ds_wr, frame_start, tag_present, ip_valid, go;
	logic        ip_is_v4, is_igmp, da_mcast, da_bcast, da_found, da_prio_en, cnt_read;
	logic        dec_valid, dec_drop, dec_learn;
	logic [1:0]  rx_port;
	logic [2:0]  tag_prio, ds_wdata, admit_non_member_mask, da_ports, da_prio, vlan_members;
	logic [2:0]  port_default_prio, dec_prio, dec_dest;
	logic [5:0]  ip_tos, ds_idx, port_spanning_state, p;
	logic [11:0] tag_vid, dec_vid;
	logic [15:0] reg_addr, g;
	logic [31:0] reg_wdata, reg_rdata, cnt_value, cnt_reload;
	logic [35:0] port_default_vlan_id;
	integer      seed = 11, err_count = 0, n_tests = 0, i, k, ep;
	ingress_rules i_ingress_rules (.*);
	frame_src i_frame_src (.clk, .go, .fs(frame_start), .h({rx_port, tag_present, tag_vid,
		tag_prio, ip_valid, ip_is_v4, ip_tos, is_igmp, da_mcast, da_bcast, da_found,
		da_ports, da_prio_en, da_prio, vlan_members, port_default_prio}));
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	task chk(input logic [31:0] s, e);
		n_tests = n_tests + 1;
		if (s !== e) begin
			err_count = err_count + 1;
			$display("BAD %0t seen %h want %h", $time, s, e);
		end
	endtask
	task wr(input logic [15:0] a, input logic [31:0] d);
		{reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
		@(posedge clk) #1 reg_wr = 0;
		@(posedge clk) #1;
		if (a == `GLOBAL_INGRESS_RULES_IDX) g = d[15:0];
		if (a == `PER_PORT_INGRESS_RULES_IDX) p = d[5:0];
	endtask
	task rd(input logic [15:0] a, input logic [31:0] e);
		{reg_addr, reg_rd} = {a, 1'b1};
		@(posedge clk) #1 reg_rd = 0;
		chk(reg_rdata, e);
		@(posedge clk) #1;
	endtask
	task frm;
		logic tg, ipu, el, ed;
		logic [2:0] mo;
		logic [11:0] ev;
		{go, port_spanning_state, admit_non_member_mask} = {1'b1, 9'($random(seed))};
		port_default_vlan_id = {$random(seed), $random(seed)};
		@(posedge clk) #1 go = 0;
		@(posedge clk);
		{tg, ipu} = {g[14] & tag_present, g[9] & ip_valid};
		ep = g[5] & da_found & da_prio_en ? da_prio : tg & (g[1] | !ipu) ? tag_prio :
			ipu ? (ip_is_v4 & g[2] ? ip_tos[5:3] : ip_tos * 5 % 8) : port_default_prio;
		el = p[3 + rx_port] & !port_spanning_state[2 * rx_port];
		ed = g[3] & !(da_found | da_mcast | da_bcast | is_igmp);
		ev = g[15] | !tag_present | tag_vid == 0 ? port_default_vlan_id[12 * rx_port +: 12] : tag_vid;
		mo = g[7] & is_igmp & ip_valid & ip_is_v4 ? g[12:10] & ~(g[13] ? 3'h0 : 3'h1 << rx_port) : 0;
		#1 chk(dec_valid, 1);
		chk(dec_learn, el);
		chk(dec_prio, ep);
		chk(dec_dest & mo, mo);
		if (g[0]) chk(dec_vid, ev);
		if (ed) chk(dec_drop, 1);
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		{go, reg_wr, reg_rd, ds_wr, cnt_read, rst_n, reg_addr, reg_wdata, cnt_value} = 0;
		{ds_idx, ds_wdata, port_spanning_state, port_default_vlan_id, admit_non_member_mask} = 0;
		{g, p} = {`GLOBAL_RESET, `PER_PORT_RESET};
		repeat (8) @(posedge clk);
		#1 rst_n = 1;
		rd(`GLOBAL_INGRESS_RULES_IDX, g);
		rd(`PER_PORT_INGRESS_RULES_IDX, p);
		// the priority table powers up undefined, so every index is loaded first
		ds_wr = 1;
		for (k = 0; k < 64; k++) begin
			{ds_idx, ds_wdata} = {6'(k), 3'(k * 5)};
			@(posedge clk) #1;
		end
		ds_wr = 0;
		$display("reset and table load done");
		for (i = 0; i < 16; i++) begin
			wr(`GLOBAL_INGRESS_RULES_IDX, $random(seed) & 32'hFFFF_FEFF);
			wr(`PER_PORT_INGRESS_RULES_IDX, $random(seed));
			wr(16'h1842, $random(seed));
			rd(16'h1842, 0);
			rd(`GLOBAL_INGRESS_RULES_IDX, g);
			rd(`PER_PORT_INGRESS_RULES_IDX, p);
			{cnt_value, cnt_read} = {$random(seed), 1'b1};
			@(posedge clk) #1 cnt_read = 0;
			chk(cnt_reload, g[6] ? `CNT_TEST_VALUE : 0);
			repeat (10) frm;
			$display("config %0d done", i);
		end
		test_done;
	end
endmodule
bind ingress_rules ingress_rules_chk i_chk (.*);
